//--- hw/compare_timer_pkg.sv
// Constants and types shared by the triggered compare timer
package compare_timer_pkg;

  // Register byte addresses
  localparam logic [15:0] ADDR_CTRL0 = 16'hffb8;
  localparam logic [15:0] ADDR_STATUS = 16'hffb9;
  localparam logic [15:0] ADDR_CMP_A = 16'hffba;
  localparam logic [15:0] ADDR_CMP_B = 16'hffbb;
  localparam logic [15:0] ADDR_COUNT = 16'hffbc;
  localparam logic [15:0] ADDR_CTRL1 = 16'hffbd;

  // Reset values
  localparam logic [7:0] RST_CTRL0 = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h10;
  localparam logic [7:0] RST_CMP = 8'hff;
  localparam logic [7:0] RST_COUNT = 8'h00;
  localparam logic [7:0] RST_CTRL1 = 8'he2;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // timer_control_0 fields
  localparam int C0_IRQ_EN_B = 7;
  localparam int C0_IRQ_EN_A = 6;
  localparam int C0_WRAP_EN = 5;
  localparam int C0_CLR_HI = 4;
  localparam int C0_CLR_LO = 3;
  localparam int C0_CKS_HI = 2;

  // timer_control_status fields
  localparam int ST_FLAG_HI = 7;
  localparam int ST_FLAG_LO = 5;
  localparam int ST_OS_HI = 3;

  // timer_control_1 fields
  localparam int C1_EDGE_HI = 4;
  localparam int C1_EDGE_LO = 3;
  localparam int C1_TRIG_EN = 2;
  localparam int C1_TAP_SEL = 0;
  localparam logic [2:0] C1_FIXED_ONES = 3'h7;

  // Clear source codes
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_MATCH_A = 2'h1;
  localparam logic [1:0] CLR_MATCH_B = 2'h2;
  localparam logic [1:0] CLR_EXT = 2'h3;

  // Clock select codes
  localparam logic [2:0] CKS_OFF = 3'h0;
  localparam logic [2:0] CKS_DIV4 = 3'h1;
  localparam logic [2:0] CKS_DIV16 = 3'h2;
  localparam logic [2:0] CKS_DIV64 = 3'h3;
  localparam logic [2:0] CKS_OFF2 = 3'h4;
  localparam logic [2:0] CKS_EXT_RISE = 3'h5;
  localparam logic [2:0] CKS_EXT_FALL = 3'h6;
  localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

  // Prescaler tap indices: bit n-1 falls once per 2^n clocks
  localparam int TAP_DIV4 = 1;
  localparam int TAP_DIV8 = 2;
  localparam int TAP_DIV16 = 3;
  localparam int TAP_DIV32 = 4;
  localparam int TAP_DIV64 = 5;
  localparam int TAP_DIV128 = 6;
  localparam int PRESCALE_BITS_DEF = 7;

  // Trigger edge and output action codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [1:0] OUT_KEEP = 2'h0;
  localparam logic [1:0] OUT_LOW = 2'h1;
  localparam logic [1:0] OUT_HIGH = 2'h2;
  localparam logic [1:0] OUT_TOGGLE = 2'h3;

  typedef struct packed {
    logic rise;
    logic fall;
  } pin_edges_type;

endpackage : compare_timer_pkg

//--- hw/pin_edge_sync.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync
  import compare_timer_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Pin and edges
  input wire logic pin,
  output pin_edges_type edges
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // Edges come only from the second and third stages
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end
    else
    begin
      meta_r <= pin;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign edges.rise = sync_r & ~last_r;
  assign edges.fall = ~sync_r & last_r;

endmodule : pin_edge_sync
`default_nettype wire

//--- hw/tap_prescaler.sv
// Free-running prescaler giving a falling-edge pulse per tap
`timescale 1ns/1ps
`default_nettype none
module tap_prescaler #(
  parameter int BITS = 7
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Tap falling edges
  output logic [BITS-1:0] tap_fall
);

  logic [BITS-1:0] cnt_r;
  logic [BITS-1:0] last_r;

  if (BITS < 2)
  begin : g_chk
    $error("tap_prescaler needs at least two bits");
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
      last_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
      last_r <= cnt_r;
    end
  end

  assign tap_fall = last_r & ~cnt_r;

endmodule : tap_prescaler
`default_nettype wire

//--- hw/triggered_compare_timer.sv
// 8-bit triggered compare timer with register port and waveform output
// Overview of operation
// - Eight-bit up-counter, software read and write
// - Wrap from ff to 00 sets flag
// - Counter zero on reset and low power
// - Compare A continuous, skipped during its write
// - Compare B works like compare A
// - Compare registers reset to all ones
// - Match A request needs flag and enable
// - Match B request needs flag and enable
// - Wrap request needs flag and enable
// - Clear source: none, A, B, pin rise
// - Trigger mode halts counter after each clear
// - Without trigger, counting continues after clear
// - Internal taps divide by 4 to 128
// - Codes 000 and 100 stop the clock
// - External clock: rise, fall or both edges
// - Control register 0 clears on reset, low power
// - Status flags cleared only by writing zero, reset or low power
// - Trigger pin starts counting on chosen edge
// - Two matches drive the waveform output
// - Output action per channel, low after reset
// - Conflicts: toggle beats high beats low
// - Clear needs prior read of one
// - Edge field codes; enabling trigger halts counter
`timescale 1ns/1ps
`default_nettype none
module triggered_compare_timer
  import compare_timer_pkg::*;
#(
  parameter int PRESCALE_BITS = PRESCALE_BITS_DEF
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  // Power states
  input wire logic standby_mode,
  input wire logic sub_mode,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Timer pins
  input wire logic ext_clock_pin,
  input wire logic ext_reset_pin,
  input wire logic trigger_pin,
  output logic wave_out_pin,
  // Interrupt requests
  output logic match_irq_a,
  output logic match_irq_b,
  output logic wrap_irq
);

  if (PRESCALE_BITS < TAP_DIV128 + 1)
  begin : g_chk
    $error("prescaler too short for the divide-by-128 tap");
  end

  logic [7:0] ctrl0_r;
  logic [3:0] out_sel_r;
  logic [2:0] flags_r;
  logic [2:0] armed_r;
  logic [1:0] edge_sel_r;
  logic trig_en_r;
  logic tap_sel_r;
  logic [7:0] cmp_a_r;
  logic [7:0] cmp_b_r;
  logic [7:0] count_r;
  logic [7:0] rdata_r;
  logic run_r;
  logic eq_a_last_r;
  logic eq_b_last_r;
  logic wave_r;

  logic [PRESCALE_BITS-1:0] tap_fall;
  pin_edges_type clk_edges;
  pin_edges_type rst_edges;
  pin_edges_type trg_edges;

  logic low_power;
  logic wr_ctrl0, wr_status, wr_cmp_a, wr_cmp_b, wr_count, wr_ctrl1, rd_status;
  logic [1:0] clr_sel;
  logic [2:0] cks;
  logic tick, tick_live;
  logic eq_a, eq_b, match_a, match_b;
  logic match_clear, ext_clear, clear_event, wrap_event, trig_hit;
  logic [2:0] flag_set, flag_clr;
  logic [1:0] act_a, act_b;
  logic [7:0] count_nxt;

  // Pin conditioning and prescaler
  pin_edge_sync u_clk_sync (.clk(clk), .rst_n(rst_n), .pin(ext_clock_pin), .edges(clk_edges));
  pin_edge_sync u_rst_sync (.clk(clk), .rst_n(rst_n), .pin(ext_reset_pin), .edges(rst_edges));
  pin_edge_sync u_trg_sync (.clk(clk), .rst_n(rst_n), .pin(trigger_pin), .edges(trg_edges));
  tap_prescaler #(.BITS(PRESCALE_BITS)) u_pre (.clk(clk), .rst_n(rst_n), .tap_fall(tap_fall));

  assign low_power = standby_mode | sub_mode;

  // Address decode
  always_comb
  begin
    wr_ctrl0 = 1'b0;
    wr_status = 1'b0;
    wr_cmp_a = 1'b0;
    wr_cmp_b = 1'b0;
    wr_count = 1'b0;
    wr_ctrl1 = 1'b0;
    if (wr && addr == ADDR_CTRL0)
      wr_ctrl0 = 1'b1;
    else if (wr && addr == ADDR_STATUS)
      wr_status = 1'b1;
    else if (wr && addr == ADDR_CMP_A)
      wr_cmp_a = 1'b1;
    else if (wr && addr == ADDR_CMP_B)
      wr_cmp_b = 1'b1;
    else if (wr && addr == ADDR_COUNT)
      wr_count = 1'b1;
    else if (wr && addr == ADDR_CTRL1)
      wr_ctrl1 = 1'b1;
  end

  assign rd_status = rd && addr == ADDR_STATUS;
  assign clr_sel = ctrl0_r[C0_CLR_HI:C0_CLR_LO];
  assign cks = ctrl0_r[C0_CKS_HI:0];

  // Count clock selection
  always_comb
  begin
    case (cks)
      CKS_DIV4: tick = tap_sel_r ? tap_fall[TAP_DIV8] : tap_fall[TAP_DIV4];
      CKS_DIV16: tick = tap_sel_r ? tap_fall[TAP_DIV32] : tap_fall[TAP_DIV16];
      CKS_DIV64: tick = tap_sel_r ? tap_fall[TAP_DIV128] : tap_fall[TAP_DIV64];
      CKS_EXT_RISE: tick = clk_edges.rise;
      CKS_EXT_FALL: tick = clk_edges.fall;
      CKS_EXT_BOTH: tick = clk_edges.rise | clk_edges.fall;
      default: tick = 1'b0;
    endcase
  end

  assign tick_live = tick & run_r;

  // A write to compare A hides its comparison for that cycle
  assign eq_a = (count_r == cmp_a_r) && !wr_cmp_a;
  assign eq_b = (count_r == cmp_b_r) && !wr_cmp_b;
  assign match_a = eq_a & ~eq_a_last_r;
  assign match_b = eq_b & ~eq_b_last_r;

  // Clear on match takes effect at the count edge after the match
  assign match_clear = (clr_sel == CLR_MATCH_A && eq_a) || (clr_sel == CLR_MATCH_B && eq_b);
  assign ext_clear = clr_sel == CLR_EXT && rst_edges.rise;
  assign clear_event = !wr_count && (ext_clear || (tick_live && match_clear));
  assign wrap_event = !wr_count && !ext_clear && tick_live && !match_clear
                      && count_r == COUNT_MAX;

  always_comb
  begin
    case (edge_sel_r)
      EDGE_RISE: trig_hit = trg_edges.rise;
      EDGE_FALL: trig_hit = trg_edges.fall;
      EDGE_BOTH: trig_hit = trg_edges.rise | trg_edges.fall;
      default: trig_hit = 1'b0;
    endcase
  end

  // Counter
  always_comb
  begin
    count_nxt = count_r;
    if (wr_count)
      count_nxt = wdata;
    else if (ext_clear)
      count_nxt = '0;
    else if (tick_live)
      count_nxt = match_clear ? 8'h00 : count_r + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || low_power)
      count_r <= RST_COUNT;
    else
      count_r <= count_nxt;
  end

  // Run state: stopped by trigger mode, restarted by a trigger edge
  always_ff @(posedge clk)
  begin
    if (!rst_n || sub_mode)
      run_r <= 1'b1;
    else if (wr_ctrl1 && wdata[C1_TRIG_EN] && !trig_en_r)
      run_r <= 1'b0;
    else if (trig_en_r && clr_sel != CLR_NONE && clear_event)
      run_r <= 1'b0;
    else if (trig_en_r && trig_hit)
      run_r <= 1'b1;
    else if (!trig_en_r)
      run_r <= 1'b1;
  end

  // Compare registers
  always_ff @(posedge clk)
  begin
    if (!rst_n || low_power)
    begin
      cmp_a_r <= RST_CMP;
      cmp_b_r <= RST_CMP;
    end
    else
    begin
      if (wr_cmp_a)
        cmp_a_r <= wdata;
      if (wr_cmp_b)
        cmp_b_r <= wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || low_power)
    begin
      eq_a_last_r <= 1'b0;
      eq_b_last_r <= 1'b0;
    end
    else
    begin
      eq_a_last_r <= eq_a;
      eq_b_last_r <= eq_b;
    end
  end

  // Control registers
  always_ff @(posedge clk)
  begin
    if (!rst_n || low_power)
      ctrl0_r <= RST_CTRL0;
    else if (wr_ctrl0)
      ctrl0_r <= wdata;
  end

  // Standby keeps timer_control_1, the other low-power states reset it
  always_ff @(posedge clk)
  begin
    if (!rst_n || sub_mode)
    begin
      edge_sel_r <= RST_CTRL1[C1_EDGE_HI:C1_EDGE_LO];
      trig_en_r <= RST_CTRL1[C1_TRIG_EN];
      tap_sel_r <= RST_CTRL1[C1_TAP_SEL];
    end
    else if (wr_ctrl1)
    begin
      edge_sel_r <= wdata[C1_EDGE_HI:C1_EDGE_LO];
      trig_en_r <= wdata[C1_TRIG_EN];
      tap_sel_r <= wdata[C1_TAP_SEL];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || low_power)
      out_sel_r <= RST_STATUS[ST_OS_HI:0];
    else if (wr_status)
      out_sel_r <= wdata[ST_OS_HI:0];
  end

  // Status flags {b, a, wrap}; a set in the clearing cycle wins
  assign flag_set = {match_b, match_a, wrap_event};
  assign flag_clr = wr_status ? (~wdata[ST_FLAG_HI:ST_FLAG_LO] & armed_r) : 3'h0;

  always_ff @(posedge clk)
  begin
    if (!rst_n || low_power)
    begin
      flags_r <= RST_STATUS[ST_FLAG_HI:ST_FLAG_LO];
      armed_r <= 3'h0;
    end
    else
    begin
      flags_r <= flag_set | (flags_r & ~flag_clr);
      armed_r <= rd_status ? (armed_r | flags_r) & ~flag_clr : armed_r & ~flag_clr;
    end
  end

  // Waveform output
  assign act_a = match_a ? out_sel_r[1:0] : OUT_KEEP;
  assign act_b = match_b ? out_sel_r[3:2] : OUT_KEEP;

  always_ff @(posedge clk)
  begin
    if (!rst_n || low_power)
      wave_r <= 1'b0;
    else if (act_a == OUT_TOGGLE || act_b == OUT_TOGGLE)
      wave_r <= ~wave_r;
    else if (act_a == OUT_HIGH || act_b == OUT_HIGH)
      wave_r <= 1'b1;
    else if (act_a == OUT_LOW || act_b == OUT_LOW)
      wave_r <= 1'b0;
  end

  assign wave_out_pin = wave_r;

  // Read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else if (!rd)
      rdata_r <= 8'h00;
    else if (addr == ADDR_CTRL0)
      rdata_r <= ctrl0_r;
    else if (addr == ADDR_STATUS)
      rdata_r <= {flags_r, RST_STATUS[4], out_sel_r};
    else if (addr == ADDR_CMP_A)
      rdata_r <= cmp_a_r;
    else if (addr == ADDR_CMP_B)
      rdata_r <= cmp_b_r;
    else if (addr == ADDR_COUNT)
      rdata_r <= count_r;
    else if (addr == ADDR_CTRL1)
      rdata_r <= {C1_FIXED_ONES, edge_sel_r, trig_en_r, 1'b1, tap_sel_r};
    else
      rdata_r <= 8'h00;
  end

  assign rdata = rdata_r;

  // Requests are levels; they drop as soon as the flag or enable does
  assign match_irq_a = flags_r[1] & ctrl0_r[C0_IRQ_EN_A];
  assign match_irq_b = flags_r[2] & ctrl0_r[C0_IRQ_EN_B];
  assign wrap_irq = flags_r[0] & ctrl0_r[C0_WRAP_EN];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_div4_cfg;
    cks == CKS_DIV4 && !tap_sel_r && !low_power;
  endsequence

  a_count_write: assert property (wr_count && !low_power |=> count_r == $past(wdata))
    else $error("counter did not take the software write");
  a_wrap_flag: assert property (wrap_event && !low_power |=> flags_r[0] && count_r == 8'h00)
    else $error("wrap did not set the flag");
  a_low_power: assert property (low_power |=> count_r == 8'h00 && cmp_a_r == 8'hff)
    else $error("low power did not reset counter and compare");
  a_cmp_hidden: assert property (wr_cmp_a && !flags_r[1] && !low_power |=> !flags_r[1])
    else $error("compare A matched during its own write");
  a_irq_pair: assert property (match_irq_a == (flags_r[1] && ctrl0_r[6]))
    else $error("match A request disagrees with flag and enable");
  a_clock_off: assert property ((cks == CKS_OFF || cks == CKS_OFF2) && !wr_count && !ext_clear
    && !low_power |=> $stable(count_r))
    else $error("counter moved with its clock off");
  a_flag_no_set: assert property (!flags_r[2] && !match_b |=> !flags_r[2])
    else $error("match B flag set without a match");
  a_trig_halt: assert property (trig_en_r && clr_sel != CLR_NONE && clear_event && !low_power
    |=> !run_r ##1 (!run_r || $past(trig_hit)))
    else $error("counter kept running after a trigger-mode clear");
  a_tap_rate: assert property ((tick && cks == CKS_DIV4 && !tap_sel_r) ##1 s_div4_cfg [*4]
    |-> tick)
    else $error("divide-by-4 tap period wrong");
  a_wave_quiet: assert property (out_sel_r == 4'h0 && !low_power |=> $stable(wave_r))
    else $error("waveform changed with outputs disabled");

endmodule : triggered_compare_timer
`default_nettype wire

//--- sim/pin_source.sv
// Model of the far side: external count clock, counter reset and trigger pins
`timescale 1ns/1ps
`default_nettype none
module pin_source
(
  // System
  input wire logic clk,
  // Pins
  output logic ext_clock_pin,
  output logic ext_reset_pin,
  output logic trigger_pin
);
  initial
  begin
    ext_clock_pin = 1'b0;
    ext_reset_pin = 1'b0;
    trigger_pin = 1'b0;
  end

  // Each level is held six cycles, well past the two-stage synchroniser
  task automatic pulse(input int which, input int n);
    int i;
    for (i = 0; i < 2 * n; i++)
    begin
      @(posedge clk);
      case (which)
        0: ext_clock_pin <= ~ext_clock_pin;
        1: ext_reset_pin <= ~ext_reset_pin;
        default: trigger_pin <= ~trigger_pin;
      endcase
      repeat (5) @(posedge clk);
    end
  endtask : pulse
endmodule : pin_source
`default_nettype wire

//--- sim/triggered_compare_timer_tb.sv
// Self-checking bench for the triggered compare timer
`timescale 1ns/1ps
`default_nettype none
module triggered_compare_timer_tb
  import compare_timer_pkg::*;
;
  logic clk, rst_n, standby_mode, sub_mode, wr, rd;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, v, mx;
  logic ext_clock_pin, ext_reset_pin, trigger_pin;
  logic wave_out_pin, match_irq_a, match_irq_b, wrap_irq;
  logic seen_hi, seen_lo;
  int miscompares, check_count, i, c, t;
  logic [15:0] reg_addr [6] = '{ADDR_CTRL0, ADDR_STATUS, ADDR_CMP_A, ADDR_CMP_B,
                                ADDR_COUNT, ADDR_CTRL1};
  logic [7:0] reg_rst [6] = '{RST_CTRL0, RST_STATUS, RST_CMP, RST_CMP, RST_COUNT, RST_CTRL1};
  logic [7:0] ext_exp [4] = '{8'h00, 8'h03, 8'h03, 8'h06};

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  triggered_compare_timer u_dut (
    .clk(clk), .rst_n(rst_n), .standby_mode(standby_mode), .sub_mode(sub_mode),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_clock_pin(ext_clock_pin), .ext_reset_pin(ext_reset_pin),
    .trigger_pin(trigger_pin), .wave_out_pin(wave_out_pin),
    .match_irq_a(match_irq_a), .match_irq_b(match_irq_b), .wrap_irq(wrap_irq)
  );

  pin_source u_pins (
    .clk(clk), .ext_clock_pin(ext_clock_pin), .ext_reset_pin(ext_reset_pin),
    .trigger_pin(trigger_pin)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic expect_reg(input string what, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    check(what, d, e);
  endtask : expect_reg

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic watch_wave(input int n);
    seen_hi = 1'b0;
    seen_lo = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      if (wave_out_pin === 1'b1)
        seen_hi = 1'b1;
      if (wave_out_pin === 1'b0)
        seen_lo = 1'b1;
    end
  endtask : watch_wave

  task automatic give_verdict();
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // Whole run is a few thousand cycles
  initial
  begin
    #3000000;
    miscompares++;
    give_verdict();
  end

  initial
  begin
    rst_n = 1'b0;
    standby_mode = 1'b0;
    sub_mode = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    miscompares = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++)
      expect_reg("reset", reg_addr[i], reg_rst[i]);
    expect_reg("hole", 16'hffbe, 8'h00);
    // Eight ticks of every internal tap, one tick of slack for phase
    for (c = 1; c < 4; c++)
      for (t = 0; t < 2; t++)
      begin
        wr_reg(ADDR_CTRL1, {7'h0, t[0]});
        wr_reg(ADDR_COUNT, 8'h00);
        wr_reg(ADDR_CTRL0, {5'h0, c[2:0]});
        repeat (32 << (2 * c - 2 + t)) @(posedge clk);
        rd_reg(ADDR_COUNT, v);
        check("rate", {7'h0, (v >= 8'h07 && v <= 8'h09)}, 8'h01);
        wr_reg(ADDR_CTRL0, 8'h00);
      end
    // Wrap through ff also matches both compares at their reset value
    do_reset();
    wr_reg(ADDR_COUNT, 8'hfc);
    wr_reg(ADDR_CTRL0, 8'h21);
    repeat (30) @(posedge clk);
    wr_reg(ADDR_CTRL0, 8'h20);
    expect_reg("st", ADDR_STATUS, 8'hf0);
    check("irqs", {5'h0, match_irq_a, match_irq_b, wrap_irq}, 8'h01);
    wr_reg(ADDR_CTRL0, 8'hc0);
    // Enables land at this edge; let them settle before looking
    #1;
    check("irqs", {5'h0, match_irq_a, match_irq_b, wrap_irq}, 8'h06);
    wr_reg(ADDR_STATUS, 8'he0);
    expect_reg("st1", ADDR_STATUS, 8'hf0);
    wr_reg(ADDR_STATUS, 8'h00);
    expect_reg("st0", ADDR_STATUS, 8'h10);
    check("irqs", {5'h0, match_irq_a, match_irq_b, wrap_irq}, 8'h00);
    check("wave", {7'h0, wave_out_pin}, 8'h00);
    // Clear on compare A, free running
    do_reset();
    wr_reg(ADDR_CMP_A, 8'h05);
    wr_reg(ADDR_CTRL0, 8'h49);
    mx = 8'h00;
    repeat (16)
    begin
      rd_reg(ADDR_COUNT, v);
      if (v > mx)
        mx = v;
    end
    check("max", mx, 8'h05);
    expect_reg("sta", ADDR_STATUS, 8'h50);
    check("irqa", {7'h0, match_irq_a}, 8'h01);
    // Waveform: A drives low, B drives high and clears
    do_reset();
    wr_reg(ADDR_CMP_A, 8'h01);
    wr_reg(ADDR_CMP_B, 8'h03);
    wr_reg(ADDR_STATUS, 8'h09);
    wr_reg(ADDR_CTRL0, 8'h91);
    watch_wave(40);
    check("wave", {6'h0, seen_hi, seen_lo}, 8'h03);
    check("irqb", {7'h0, match_irq_b}, 8'h01);
    wr_reg(ADDR_CMP_A, 8'h03);
    wr_reg(ADDR_STATUS, 8'h06);
    repeat (20) @(posedge clk);
    watch_wave(40);
    check("high", {6'h0, seen_hi, seen_lo}, 8'h02);
    wr_reg(ADDR_STATUS, 8'h0d);
    watch_wave(40);
    check("tgl", {6'h0, seen_hi, seen_lo}, 8'h03);
    // Zero writes above came with no earlier status read, so both flags stay
    expect_reg("keep", ADDR_STATUS, 8'hdd);
    // Off code 100, then the external clock codes
    do_reset();
    for (c = 4; c < 8; c++)
    begin
      wr_reg(ADDR_CTRL0, {5'h0, c[2:0]});
      wr_reg(ADDR_COUNT, 8'h00);
      u_pins.pulse(0, 3);
      repeat (8) @(posedge clk);
      expect_reg("ext", ADDR_COUNT, ext_exp[c - 4]);
    end
    wr_reg(ADDR_CTRL0, 8'h18);
    wr_reg(ADDR_COUNT, 8'h40);
    expect_reg("held", ADDR_COUNT, 8'h40);
    u_pins.pulse(1, 1);
    expect_reg("xrst", ADDR_COUNT, 8'h00);
    // Trigger on rising edge, halt after each clear
    do_reset();
    wr_reg(ADDR_CMP_A, 8'h02);
    wr_reg(ADDR_CTRL1, 8'h0c);
    wr_reg(ADDR_CTRL0, 8'h09);
    repeat (20) @(posedge clk);
    expect_reg("c1", ADDR_CTRL1, 8'hee);
    expect_reg("halt", ADDR_COUNT, 8'h00);
    u_pins.pulse(2, 1);
    repeat (20) @(posedge clk);
    expect_reg("trg", ADDR_STATUS, 8'h50);
    expect_reg("stop", ADDR_COUNT, 8'h00);
    // Low-power states
    wr_reg(ADDR_CTRL1, 8'h01);
    @(posedge clk);
    standby_mode <= 1'b1;
    @(posedge clk);
    standby_mode <= 1'b0;
    expect_reg("sb0", ADDR_CTRL0, RST_CTRL0);
    expect_reg("sba", ADDR_CMP_A, RST_CMP);
    expect_reg("sb1", ADDR_CTRL1, 8'he3);
    @(posedge clk);
    sub_mode <= 1'b1;
    @(posedge clk);
    sub_mode <= 1'b0;
    expect_reg("sub1", ADDR_CTRL1, RST_CTRL1);
    give_verdict();
  end
endmodule : triggered_compare_timer_tb
`default_nettype wire
